// File: logic/oex_pkg.sv
// Package of register map, field positions and reset values for the port
package oex_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_PIN_DIRECTION     = 8'h00;
  localparam logic [7:0] REG_INPUT_INVERSION   = 8'h01;
  localparam logic [7:0] REG_CHANGE_IRQ_ENABLE = 8'h02;
  localparam logic [7:0] REG_COMPARE_DEFAULT   = 8'h03;
  localparam logic [7:0] REG_COMPARE_SELECT    = 8'h04;
  localparam logic [7:0] REG_EXPANDER_CONFIG   = 8'h05;
  localparam logic [7:0] REG_PULLUP_ENABLE     = 8'h06;
  localparam logic [7:0] REG_IRQ_FLAGS         = 8'h07;
  localparam logic [7:0] REG_IRQ_CAPTURE       = 8'h08;
  localparam logic [7:0] REG_PORT_PINS         = 8'h09;
  localparam logic [7:0] REG_OUTPUT_LATCH      = 8'h0A;
  localparam logic [7:0] REG_LAST              = 8'h0A;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PIN_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_ZERO          = 8'h00;

  // ---------------------------------------------------------------
  // Configuration fields
  // ---------------------------------------------------------------
  localparam int         CFG_AUTO_INCREMENT_OFF = 5;
  localparam int         CFG_OPEN_DRAIN_IRQ     = 2;
  localparam int         CFG_IRQ_ACTIVE_HIGH    = 1;
  localparam int         CFG_CLEAR_ON_CAPTURE   = 0;
  localparam logic [7:0] CFG_WRITE_MASK         = 8'h27;

  // ---------------------------------------------------------------
  // Control byte layout
  // ---------------------------------------------------------------
  localparam int         CTRL_RW_BIT   = 0;
  localparam int         STRAP_W       = 3;
  localparam int         SYNC_STAGES   = 2;

  // ---------------------------------------------------------------
  // Serial frame states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CTRL = 5'b00010,
    ST_ADDR = 5'b00100,
    ST_DATA = 5'b01000,
    ST_SKIP = 5'b10000
  } oex_state_t;

endpackage

// File: logic/oex_port.sv
// Open-drain eight-pin port with register file and serial byte front end
//
// Summary of operation
// - Two-wire builds accept a control byte of four fixed address bits, three strap bits and a read/write bit.
// - Four-wire builds accept a control byte of seven fixed address bits and a read/write bit.
// - Eight pins each either drive low or release, never drive high.
// - Each pin pull-up follows its enable bit whatever the pin direction.
// - Port value reads return sampled pins while output latch reads return the latch.
// - Writing the port value register writes the output latch.
// - Output pins drive low where the output latch bit is zero and release where it is one.
// - Input pins have their driver turned off and float unless their pull-up is enabled.
// - Eleven byte registers sit at addresses 00 to 0A in table order.
// - A direction bit of one makes an input and zero an output.
// - An inversion bit of one inverts the port value read of that pin.
// - A change enable bit of one enables change detection on that pin.
// - A compare select bit of one compares against the default bit, zero against the previous level.
// - With default compare a pin level opposite the default bit raises a flag.
// - The register pointer steps per byte unless disabled and wraps to zero after the last.
`timescale 1ns/1ps
module oex_port
  import oex_pkg::*;
#(
  parameter int         PORT_W     = 8,
  parameter int         NUM_REGS   = 11,
  parameter bit         FOUR_WIRE  = 1'b0,
  parameter logic [3:0] FIXED_HI   = 4'h5,
  parameter logic [6:0] FIXED_FULL = 7'h2A
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [STRAP_W-1:0] strap_i,
  input  wire logic              frame_start_i,
  input  wire logic              frame_end_i,
  input  wire logic              rx_valid_i,
  input  wire logic [7:0]        rx_data_i,
  input  wire logic              tx_req_i,
  output logic                   addr_ack_o,
  output logic                   tx_valid_o,
  output logic      [7:0]        tx_data_o,
  input  wire logic [PORT_W-1:0] pin_in_i,
  output logic      [PORT_W-1:0] pin_out_o,
  output logic      [PORT_W-1:0] pin_oe_n_o,
  output logic      [PORT_W-1:0] pullup_o,
  output logic                   irq_o
);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  generate
    if (PORT_W != 8 || NUM_REGS != 11) begin : g_bad_param
      $error("oex_port supports eight pins and eleven registers only");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0]  pin_direction, input_inversion;
  logic [7:0]  change_irq_enable, compare_default;
  logic [7:0]  compare_select, expander_config;
  logic [7:0]  pullup_enable, irq_flags;
  logic [7:0]  irq_capture, output_latch;
  logic [7:0]  reg_ptr, pins_prev;
  logic [STRAP_W-1:0] strap_addr;
  logic        strap_done, read_mode;
  oex_state_t  state, next_state;

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  logic [7:0]  pins_sync;

  oex_sync #(
    .WIDTH (PORT_W)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    (pin_in_i),
    .sync_o     (pins_sync)
  );

  // ---------------------------------------------------------------
  // Address match and control byte decode
  // ---------------------------------------------------------------
  logic [6:0]  own_addr;
  logic        ctrl_match, ctrl_read;

  generate
    if (FOUR_WIRE) begin : g_four_wire
      assign own_addr = FIXED_FULL;
    end else begin : g_two_wire
      assign own_addr = {FIXED_HI, strap_addr};
    end
  endgenerate

  assign ctrl_match = (rx_data_i[7:1] == own_addr);
  assign ctrl_read  = rx_data_i[CTRL_RW_BIT];

  // ---------------------------------------------------------------
  // Byte strobes
  // ---------------------------------------------------------------
  logic        byte_in, wr_strobe, rd_strobe, ptr_strobe;

  assign byte_in    = rx_valid_i && !frame_start_i && !frame_end_i;
  assign ptr_strobe = byte_in && (state == ST_ADDR);
  assign wr_strobe  = byte_in && (state == ST_DATA) && !read_mode;
  assign rd_strobe  = tx_req_i && (state == ST_DATA) && read_mode;

  logic        auto_inc_off;
  logic [7:0]  ptr_step;
  assign auto_inc_off = expander_config[CFG_AUTO_INCREMENT_OFF];
  assign ptr_step = (reg_ptr >= REG_LAST) ? RST_ZERO : reg_ptr + 8'h01;

  logic [7:0]  next_ptr;
  assign next_ptr = ptr_strobe ? rx_data_i :
                    ((wr_strobe || rd_strobe) && !auto_inc_off) ? ptr_step :
                    reg_ptr;

  // ---------------------------------------------------------------
  // Frame state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (frame_start_i) begin
          next_state = ST_CTRL;
        end
      end
      ST_CTRL: begin
        if (byte_in) begin
          if (!ctrl_match) begin
            next_state = ST_SKIP;
          end else if (ctrl_read && !FOUR_WIRE) begin
            next_state = ST_DATA;
          end else begin
            next_state = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        if (byte_in) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA, ST_SKIP: begin
        next_state = state;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (frame_end_i) begin
      next_state = ST_IDLE;
    end else if (frame_start_i) begin
      next_state = ST_CTRL;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state      <= ST_IDLE;
      read_mode  <= 1'b0;
      addr_ack_o <= 1'b0;
      reg_ptr    <= RST_ZERO;
    end else begin
      state   <= next_state;
      reg_ptr <= next_ptr;
      if (state == ST_CTRL && byte_in) begin
        read_mode  <= ctrl_read;
        addr_ack_o <= ctrl_match;
      end else if (frame_end_i || frame_start_i) begin
        addr_ack_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Strap capture after reset release
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_done <= 1'b0;
      strap_addr <= '0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      strap_addr <= strap_i;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // address decode
  logic        wr_dir, wr_inv, wr_ien, wr_def;
  logic        wr_sel, wr_cfg, wr_pu, wr_lat;
  assign wr_dir = wr_strobe && (reg_ptr == REG_PIN_DIRECTION);
  assign wr_inv = wr_strobe && (reg_ptr == REG_INPUT_INVERSION);
  assign wr_ien = wr_strobe && (reg_ptr == REG_CHANGE_IRQ_ENABLE);
  assign wr_def = wr_strobe && (reg_ptr == REG_COMPARE_DEFAULT);
  assign wr_sel = wr_strobe && (reg_ptr == REG_COMPARE_SELECT);
  assign wr_cfg = wr_strobe && (reg_ptr == REG_EXPANDER_CONFIG);
  assign wr_pu  = wr_strobe && (reg_ptr == REG_PULLUP_ENABLE);
  // port value write lands in the latch
  assign wr_lat = wr_strobe && ((reg_ptr == REG_OUTPUT_LATCH) ||
                                (reg_ptr == REG_PORT_PINS));

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_direction     <= RST_PIN_DIRECTION;
      input_inversion   <= RST_ZERO;
      change_irq_enable <= RST_ZERO;
      compare_default   <= RST_ZERO;
      compare_select    <= RST_ZERO;
      expander_config   <= RST_ZERO;
      pullup_enable     <= RST_ZERO;
      output_latch      <= RST_ZERO;
    end else begin
      if (wr_dir) pin_direction     <= rx_data_i;
      if (wr_inv) input_inversion   <= rx_data_i;
      if (wr_ien) change_irq_enable <= rx_data_i;
      if (wr_def) compare_default   <= rx_data_i;
      if (wr_sel) compare_select    <= rx_data_i;
      if (wr_cfg) expander_config   <= rx_data_i & CFG_WRITE_MASK;
      if (wr_pu)  pullup_enable     <= rx_data_i;
      if (wr_lat) output_latch      <= rx_data_i;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [7:0]  port_value;
  logic [7:0]  rd_data;

  // inversion on the port value read
  assign port_value = pins_sync ^ input_inversion;

  assign rd_data =
    (reg_ptr == REG_PIN_DIRECTION)     ? pin_direction     :
    (reg_ptr == REG_INPUT_INVERSION)   ? input_inversion   :
    (reg_ptr == REG_CHANGE_IRQ_ENABLE) ? change_irq_enable :
    (reg_ptr == REG_COMPARE_DEFAULT)   ? compare_default   :
    (reg_ptr == REG_COMPARE_SELECT)    ? compare_select    :
    (reg_ptr == REG_EXPANDER_CONFIG)   ? expander_config   :
    (reg_ptr == REG_PULLUP_ENABLE)     ? pullup_enable     :
    (reg_ptr == REG_IRQ_FLAGS)         ? irq_flags         :
    (reg_ptr == REG_IRQ_CAPTURE)       ? irq_capture       :
    (reg_ptr == REG_PORT_PINS)         ? port_value        :
    (reg_ptr == REG_OUTPUT_LATCH)      ? output_latch      :
    RST_ZERO;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= RST_ZERO;
    end else begin
      tx_valid_o <= rd_strobe;
      if (rd_strobe) tx_data_o <= rd_data;
    end
  end

  // ---------------------------------------------------------------
  // Change detection
  // ---------------------------------------------------------------
  logic [7:0]  change_hit, flag_set;
  logic        clear_req, any_set;

  generate
    for (genvar p = 0; p < PORT_W; p++) begin : g_cmp
      assign change_hit[p] = change_irq_enable[p] &&
        (compare_select[p] ? (pins_sync[p] != compare_default[p]) :
                             (pins_sync[p] != pins_prev[p]));
    end
  endgenerate

  assign flag_set  = change_hit & ~irq_flags;
  assign any_set   = |flag_set;
  assign clear_req = rd_strobe &&
    (expander_config[CFG_CLEAR_ON_CAPTURE] ?
       (reg_ptr == REG_IRQ_CAPTURE) : (reg_ptr == REG_PORT_PINS));

  // New events on pins not already flagged win over a clear in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_prev   <= RST_ZERO;
      irq_flags   <= RST_ZERO;
      irq_capture <= RST_ZERO;
    end else begin
      pins_prev <= pins_sync;
      irq_flags <= (clear_req ? RST_ZERO : irq_flags) | flag_set;
      if (any_set) irq_capture <= port_value;
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers and interrupt level
  // ---------------------------------------------------------------
  logic [7:0]  next_oe_n;
  logic        next_irq, irq_high;

  assign next_oe_n = pin_direction | output_latch;
  assign irq_high  = expander_config[CFG_IRQ_ACTIVE_HIGH] &&
                     !expander_config[CFG_OPEN_DRAIN_IRQ];
  assign next_irq  = (|irq_flags) ^ !irq_high;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_o  <= RST_ZERO;
      pin_oe_n_o <= RST_PIN_DIRECTION;
      pullup_o   <= RST_ZERO;
      irq_o      <= 1'b1;
    end else begin
      pin_out_o  <= RST_ZERO;
      pin_oe_n_o <= next_oe_n;
      pullup_o   <= pullup_enable;
      irq_o      <= next_irq;
    end
  end

endmodule // oex_port

// File: logic/oex_sync.sv
// Two-flop synchroniser for the pin levels
`timescale 1ns/1ps
module oex_sync
  import oex_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // ---------------------------------------------------------------
  // Synchroniser stages
  // ---------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
      logic meta;
      logic stable;
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta   <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta   <= async_i[b];
          stable <= meta;
        end
      end
      assign sync_o[b] = stable;
    end
  endgenerate

endmodule // oex_sync

// File: tb/oex_host_model.sv
// Host model issuing framed register accesses to the port
`timescale 1ns/1ps
module oex_host_model (
  input  wire logic       core_clk_i,
  output logic            frame_start_o,
  output logic            frame_end_o,
  output logic            rx_valid_o,
  output logic      [7:0] rx_data_o,
  output logic            tx_req_o,
  input  wire logic       addr_ack_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i
);
  logic acked;

  initial begin
    frame_start_o = 1'b0;
    frame_end_o   = 1'b0;
    rx_valid_o    = 1'b0;
    rx_data_o     = 8'h00;
    tx_req_o      = 1'b0;
    acked         = 1'b0;
  end

  task automatic send(input logic [7:0] b);
    rx_valid_o <= 1'b1;
    rx_data_o  <= b;
    @(posedge core_clk_i);
    acked = acked | addr_ack_i;
  endtask

  task automatic open_frame(input logic [6:0] dev, input logic rw);
    // Drop the last byte so a restart does not take it as data
    rx_valid_o <= 1'b0;
    @(posedge core_clk_i);
    frame_start_o <= 1'b1;
    acked = 1'b0;
    @(posedge core_clk_i);
    frame_start_o <= 1'b0;
    send({dev, rw});
  endtask

  task automatic close_frame;
    rx_valid_o  <= 1'b0;
    rx_data_o   <= ~rx_data_o;
    frame_end_o <= 1'b1;
    @(posedge core_clk_i);
    frame_end_o <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
                    input logic [7:0] q[$]);
    open_frame(dev, 1'b0);
    send(ptr);
    foreach (q[i]) send(q[i]);
    close_frame();
  endtask

  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr,
                    input int n, output logic [7:0] q[$]);
    int k;
    q = {};
    open_frame(dev, 1'b0);
    send(ptr);
    open_frame(dev, 1'b1);
    for (int i = 0; i < n; i++) begin
      rx_valid_o <= 1'b0;
      tx_req_o   <= 1'b1;
      @(posedge core_clk_i);
      tx_req_o <= 1'b0;
      k = 0;
      do begin
        @(posedge core_clk_i);
        k++;
      end while (!tx_valid_i && k < 4);
      q.push_back(tx_data_i);
    end
    close_frame();
  endtask
endmodule // oex_host_model

// File: tb/oex_port_bench.sv
// Self-checking bench for the open-drain port
`timescale 1ns/1ps
module oex_port_bench
  import oex_pkg::*;
();
  localparam logic [2:0] STRAP = 3'h3;
  localparam logic [3:0] HI    = 4'h5;
  localparam logic [6:0] DEV   = {HI, STRAP};
  logic       core_clk;
  logic       rst_n;
  logic [2:0] strap;
  logic [7:0] ext_lvl;
  logic       fs, fe, rv, tr, ack, tv, irq;
  logic [7:0] rd_b, td, pout, oe_n, pu;
  wire  logic [7:0] pin_lvl = ext_lvl & oe_n;
  int         mismatches;
  int         checks_done;

  oex_port #(.FIXED_HI(HI)) uut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .strap_i(strap),
    .frame_start_i(fs), .frame_end_i(fe), .rx_valid_i(rv),
    .rx_data_i(rd_b), .tx_req_i(tr), .addr_ack_o(ack), .tx_valid_o(tv),
    .tx_data_o(td), .pin_in_i(pin_lvl), .pin_out_o(pout),
    .pin_oe_n_o(oe_n), .pullup_o(pu), .irq_o(irq));

  oex_host_model host (
    .core_clk_i(core_clk), .frame_start_o(fs), .frame_end_o(fe),
    .rx_valid_o(rv), .rx_data_o(rd_b), .tx_req_o(tr),
    .addr_ack_i(ack), .tx_valid_i(tv), .tx_data_i(td));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic w1(input logic [7:0] ptr, input logic [7:0] d);
    host.wr(DEV, ptr, {d});
    repeat (2) @(posedge core_clk);
  endtask

  task automatic rchk(input string what, input logic [7:0] ptr,
                      input logic [7:0] exp);
    logic [7:0] q[$];
    host.rd(DEV, ptr, 1, q);
    chk(what, q[0], exp);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    #100000;
    mismatches++;
    summarize();
  end

  initial begin
    logic [7:0] q[$];
    rst_n   = 1'b0;
    strap   = STRAP;
    ext_lvl = 8'hA5;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 11; i++) begin
      rchk("reset", i[7:0], i == 9 ? 8'hA5 : (i == 0 ? 8'hFF : 8'h00));
    end
    chk("oe reset", oe_n, RST_PIN_DIRECTION);
    $display("test reset done");
    host.wr(DEV, REG_PORT_PINS, {8'h12, 8'h34, 8'hF0});
    rchk("latch", REG_OUTPUT_LATCH, 8'h34);
    rchk("dir wrap", REG_PIN_DIRECTION, 8'hF0);
    chk("drive enable", oe_n, 8'hF4);
    chk("drive level", pout, 8'h00);
    rchk("pins", REG_PORT_PINS, 8'hA4);
    w1(REG_INPUT_INVERSION, 8'hFF);
    rchk("inverted", REG_PORT_PINS, 8'h5B);
    w1(REG_INPUT_INVERSION, 8'h00);
    w1(REG_PULLUP_ENABLE, 8'h0F);
    chk("pullup", pu, 8'h0F);
    $display("test port paths done");
    w1(REG_IRQ_FLAGS, 8'hFF);
    rchk("ro flags", REG_IRQ_FLAGS, 8'h00);
    w1(8'h0B, 8'h77);
    rchk("unmapped", 8'h0B, 8'h00);
    host.wr(DEV ^ 7'h01, REG_PULLUP_ENABLE, {8'h99});
    chk("foreign ack", {7'h0, host.acked}, 8'h00);
    chk("foreign wr", pu, 8'h0F);
    w1(REG_EXPANDER_CONFIG, 8'h20);
    host.wr(DEV, REG_PULLUP_ENABLE, {8'h11, 8'h22});
    host.rd(DEV, REG_PULLUP_ENABLE, 2, q);
    chk("hold ptr a", q[0], 8'h22);
    chk("hold ptr b", q[1], 8'h22);
    rchk("flags kept", REG_IRQ_FLAGS, 8'h00);
    w1(REG_EXPANDER_CONFIG, 8'h00);
    $display("test refusals done");
    w1(REG_PIN_DIRECTION, 8'hFF);
    w1(REG_COMPARE_DEFAULT, 8'h00);
    w1(REG_CHANGE_IRQ_ENABLE, 8'h02);
    rchk("clear", REG_PORT_PINS, 8'hA5);
    rchk("no change", REG_IRQ_FLAGS, 8'h00);
    ext_lvl <= 8'hA7;
    repeat (6) @(posedge core_clk);
    chk("irq low", {7'h0, irq}, 8'h00);
    rchk("prev flag", REG_IRQ_FLAGS, 8'h02);
    rchk("clear", REG_PORT_PINS, 8'hA7);
    ext_lvl <= 8'hA3;
    repeat (6) @(posedge core_clk);
    rchk("masked", REG_IRQ_FLAGS, 8'h00);
    chk("irq idle", {7'h0, irq}, 8'h01);
    w1(REG_COMPARE_SELECT, 8'h01);
    w1(REG_CHANGE_IRQ_ENABLE, 8'h01);
    rchk("default flag", REG_IRQ_FLAGS, 8'h01);
    w1(REG_EXPANDER_CONFIG, 8'h02);
    chk("irq high", {7'h0, irq}, 8'h01);
    w1(REG_EXPANDER_CONFIG, 8'h06);
    chk("irq open drain", {7'h0, irq}, 8'h00);
    w1(REG_COMPARE_DEFAULT, 8'h01);
    w1(REG_EXPANDER_CONFIG, 8'h01);
    rchk("capture", REG_IRQ_CAPTURE, 8'hA3);
    rchk("capture clear", REG_IRQ_FLAGS, 8'h00);
    $display("test change detect done");
    summarize();
  end
endmodule // oex_port_bench

bind oex_port oex_port_props #(
  .PORT_W(PORT_W), .FOUR_WIRE(FOUR_WIRE),
  .FIXED_HI(FIXED_HI), .FIXED_FULL(FIXED_FULL)
) u_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .strap_i(strap_i),
  .frame_start_i(frame_start_i), .frame_end_i(frame_end_i),
  .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .tx_req_i(tx_req_i),
  .addr_ack_o(addr_ack_o), .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o), .pin_out_o(pin_out_o),
  .pin_oe_n_o(pin_oe_n_o), .pullup_o(pullup_o));

// File: tb/oex_port_props.sv
// Concurrent checks on the port's serial answers and pad outputs
`timescale 1ns/1ps
module oex_port_props
  import oex_pkg::*;
#(
  parameter int         PORT_W     = 8,
  parameter bit         FOUR_WIRE  = 1'b0,
  parameter logic [3:0] FIXED_HI   = 4'h5,
  parameter logic [6:0] FIXED_FULL = 7'h2A
) (
  input wire logic               core_clk_i,
  input wire logic               rst_n_i,
  input wire logic [STRAP_W-1:0] strap_i,
  input wire logic               frame_start_i,
  input wire logic               frame_end_i,
  input wire logic               rx_valid_i,
  input wire logic [7:0]         rx_data_i,
  input wire logic               tx_req_i,
  input wire logic               addr_ack_o,
  input wire logic               tx_valid_o,
  input wire logic [7:0]         tx_data_o,
  input wire logic [PORT_W-1:0]  pin_out_o,
  input wire logic [PORT_W-1:0]  pin_oe_n_o,
  input wire logic [PORT_W-1:0]  pullup_o
);
  // ---------------------------------------------------------------
  // Frame tracking
  // ---------------------------------------------------------------
  logic       ctrl_pend;
  logic       rd_frame;
  wire  logic rx_take = rx_valid_i && !frame_start_i && !frame_end_i;
  wire  logic [6:0] dev_addr = FOUR_WIRE ? FIXED_FULL : {FIXED_HI, strap_i};

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_pend <= 1'b0;
      rd_frame  <= 1'b0;
    end else if (frame_start_i || frame_end_i) begin
      ctrl_pend <= frame_start_i;
      rd_frame  <= 1'b0;
    end else if (rx_take && ctrl_pend) begin
      ctrl_pend <= 1'b0;
      rd_frame  <= rx_data_i[CTRL_RW_BIT];
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ctrl_byte;
    ctrl_pend && rx_take;
  endsequence

  a_addr_match: assert property (
    s_ctrl_byte ##0 rx_data_i[7:1] == dev_addr |=> addr_ack_o)
    else $error("matching control byte not acknowledged");
  a_addr_refuse: assert property (
    s_ctrl_byte ##0 rx_data_i[7:1] != dev_addr |=> !addr_ack_o)
    else $error("foreign control byte acknowledged");
  a_ack_cause: assert property (
    $rose(addr_ack_o) |-> $past(ctrl_pend && rx_take))
    else $error("acknowledge without control byte");
  a_ack_drop: assert property (
    frame_end_i |=> !addr_ack_o)
    else $error("acknowledge outlived frame end");
  a_read_answer: assert property (
    tx_req_i && addr_ack_o && rd_frame |=> tx_valid_o)
    else $error("read request not answered next cycle");
  a_tx_no_req: assert property (
    !tx_req_i |=> !tx_valid_o)
    else $error("read data without request");
  a_tx_data_hold: assert property (
    !tx_valid_o |-> $stable(tx_data_o))
    else $error("read data moved without valid");
  a_drive_low_only: assert property (
    pin_out_o == '0)
    else $error("pin driven high");
  a_pads_after_write: assert property (
    $changed(pin_oe_n_o) || $changed(pullup_o)
      |-> $past(rx_take && addr_ack_o, 2))
    else $error("pad controls changed without a written byte");
endmodule // oex_port_props
